// ===== hw/tmab_defines.vh
`ifndef TMAB_DEFINES_VH
`define TMAB_DEFINES_VH
// Register word addresses; timer B entries are the upper five address bits, channel in the low three
`define TMAB_A_TA_CNT 8'h00
`define TMAB_A_TA_MODE 8'h01
`define TMAB_A_START 8'h02
`define TMAB_A_TRIG 8'h03
`define TMAB_A_IRQ_STAT 8'h04
`define TMAB_A_IRQ_MASK 8'h05
`define TMAB_A_TB_CNT 5'h01
`define TMAB_A_TB_MODE 5'h02
// Timer A mode field
`define TMAB_TA_TIMER 2'h0
`define TMAB_TA_EVENT 2'h1
`define TMAB_TA_ONESHOT 2'h2
`define TMAB_TA_PWM 2'h3
`define TMAB_TA_UP 2
`define TMAB_TA_FREE 3
`define TMAB_TA_EXT 4
// Timer B mode field
`define TMAB_TB_TIMER 2'h0
`define TMAB_TB_EVENT 2'h1
`define TMAB_TB_MEAS 2'h2
`define TMAB_TB_MSEL 2
// Values
`define TMAB_ALL1 16'hFFFF
`define TMAB_ZERO 16'h0000
`define TMAB_DIV_DEFAULT 4
`define TMAB_TRIG_GUARD_NS 300
`define TMAB_CLK_MHZ 20
`endif

// ===== hw/tmab_timer_b.v
`default_nettype none
`include "tmab_defines.vh"
module tmab_timer_b (
	// Clock and reset
	input wire clk,
	input wire resetn,
	// Count source and event pin (already synchronised)
	input wire tick,
	input wire pin_lvl,
	// Control
	input wire start,
	input wire [1:0] mode,
	input wire msel,
	input wire wr_cnt,
	input wire wr_mode,
	input wire [15:0] wdata,
	// Status
	output wire [15:0] rd_val,
	output wire req,
	output wire ovf
);
reg [15:0] cnt_reg;
reg [15:0] rld_reg;
reg ovf_reg;
reg ovf_tick_reg;
reg pin_d_reg;
reg first_reg;
reg msel_d_reg;
reg start_d_reg;
wire rise = pin_lvl & ~pin_d_reg;
wire valid = msel ? (pin_lvl ^ pin_d_reg) : rise;
wire meas = start & (mode == `TMAB_TB_MEAS);
wire step = start & ((mode == `TMAB_TB_TIMER) ? tick : (mode == `TMAB_TB_EVENT) ? rise : 1'b0);
wire reload_now = step & (cnt_reg == `TMAB_ZERO);
wire ovf_set = meas & tick & (cnt_reg == `TMAB_ALL1);
wire edge_req = meas & valid & ~first_reg; // R17
wire sel_req = meas & start_d_reg & (msel != msel_d_reg); // R16
assign req = reload_now | edge_req | ovf_set | sel_req; // R18
// Measurement reads the captured value; counting reads live, all ones at reload
assign rd_val = meas ? rld_reg : (reload_now ? `TMAB_ALL1 : cnt_reg); // R15
assign ovf = ovf_reg;
always @(posedge clk)
begin
	if (!resetn)
	begin
		cnt_reg <= `TMAB_ZERO;
		rld_reg <= `TMAB_ZERO;
		ovf_reg <= 1'b0;
		ovf_tick_reg <= 1'b0;
		pin_d_reg <= 1'b0;
		first_reg <= 1'b1;
		msel_d_reg <= 1'b0;
		start_d_reg <= 1'b0;
	end
	else
	begin
		pin_d_reg <= pin_lvl;
		msel_d_reg <= msel;
		start_d_reg <= start;
		if (wr_cnt)
			rld_reg <= wdata;
		if (wr_cnt && !start)
			cnt_reg <= wdata; // R15
		else if (reload_now)
			cnt_reg <= rld_reg;
		else if (step)
			cnt_reg <= cnt_reg - 16'h0001;
		else if (meas && valid)
		begin
			// First capture carries the unknown start value and raises no request
			if (!wr_cnt)
				rld_reg <= cnt_reg; // R17
			cnt_reg <= `TMAB_ZERO;
		end
		else if (meas && tick)
			cnt_reg <= cnt_reg + 16'h0001; // R18
		if (!start)
			first_reg <= 1'b1;
		else if (meas && valid)
			first_reg <= 1'b0;
		// Set wins over the clear by mode write
		if (ovf_set)
		begin
			ovf_reg <= 1'b1;
			ovf_tick_reg <= 1'b0;
		end
		else if (wr_mode && ovf_tick_reg)
		begin
			ovf_reg <= 1'b0; // R19
			ovf_tick_reg <= 1'b0;
		end
		else if (ovf_reg && tick)
			ovf_tick_reg <= 1'b1; // R19
	end
end
endmodule // tmab_timer_b
`default_nettype wire

// ===== hw/tmab_top.v
// Function
// R1: Timer A read gives live count; FFFF on underflow reload, 0000 on overflow.
// R2: Value written while stopped reads back before counting starts.
// R3: Software loads every timer register before starting it.
// R4: Software rewrites a free-run event counter after stopping it.
// R5: Software sets free-run start value via reload, then rewrites 0000 or FFFF.
// R6: Direction changes start in reload type; free-run after first pulse.
// R7: One-shot stop: counter stops, reloads, output low, request set.
// R8: One-shot output starts on count-source tick, up to one cycle late.
// R9: Entering one-shot from reset, timer or event mode sets request.
// R10: Retrigger: one more down count, then reload and continue.
// R11: Retriggers are spaced more than one count-source cycle apart.
// R12: No external trigger within 300 ns before the count reaches zero.
// R13: Entering PWM from reset, timer or event mode sets request.
// R14: PWM stop: high output goes low with request; low output stays, none.
// R15: Timer B reads live count, FFFF at reload, written value while stopped.
// R16: Changing measurement selection after start sets timer B request.
// R17: First valid edge captures unknown value and raises no request.
// R18: Overflow flag and requests may occur before the first valid edge.
// R19: Mode write at or after next tick after overflow clears the flag.
`default_nettype none
`include "tmab_defines.vh"
module tmab_top #(
	parameter DIV = `TMAB_DIV_DEFAULT,
	parameter NB = 6
) (
	// Clock and reset
	input wire clk,
	input wire resetn,
	// Register port
	input wire [7:0] addr,
	input wire [15:0] wdata,
	input wire wr,
	input wire rd,
	output reg [15:0] rdata,
	// Pins
	input wire timer_a_trigger_input,
	input wire [NB-1:0] timer_b_input,
	output reg timer_a_output_pin,
	// Interrupt
	output reg irq
);
localparam ST_IDLE = 3'b001;
localparam ST_RUN = 3'b010;
localparam ST_RETRIG = 3'b100;
localparam NI = NB + 1;
localparam DW = 8;

function is_tb;
	input [7:0] a;
	input [4:0] kind;
	begin
		is_tb = (a[7:3] == kind) && (a[2:0] < NB);
	end
endfunction

// Count source prescaler
reg [DW-1:0] div_reg;
reg tick_reg;
always @(posedge clk)
begin
	if (!resetn)
	begin
		div_reg <= {DW{1'b0}};
		tick_reg <= 1'b0;
	end
	else if (div_reg == DIV[DW-1:0] - 1'b1)
	begin
		div_reg <= {DW{1'b0}};
		tick_reg <= 1'b1;
	end
	else
	begin
		div_reg <= div_reg + 1'b1;
		tick_reg <= 1'b0;
	end
end

// Pin synchronisers; logic reads the second stage and, for timer A, its delayed copy ta_d_reg
reg ta_s1_reg;
reg ta_s2_reg;
reg ta_d_reg;
reg [NB-1:0] tb_s1_reg;
reg [NB-1:0] tb_s2_reg;
always @(posedge clk)
begin
	if (!resetn)
	begin
		ta_s1_reg <= 1'b0;
		ta_s2_reg <= 1'b0;
		ta_d_reg <= 1'b0;
		tb_s1_reg <= {NB{1'b0}};
		tb_s2_reg <= {NB{1'b0}};
	end
	else
	begin
		ta_s1_reg <= timer_a_trigger_input;
		ta_s2_reg <= ta_s1_reg;
		ta_d_reg <= ta_s2_reg;
		tb_s1_reg <= timer_b_input;
		tb_s2_reg <= tb_s1_reg;
	end
end
wire ta_rise = ta_s2_reg & ~ta_d_reg;

// Control registers
reg [4:0] ta_mode_reg;
reg [NI-1:0] start_reg;
reg [NI-1:0] stat_reg;
reg [NI-1:0] mask_reg;
wire [2:0] tb_mode [0:NB-1];
wire wr_ta_cnt = wr && (addr == `TMAB_A_TA_CNT);
wire wr_ta_mode = wr && (addr == `TMAB_A_TA_MODE);
wire wr_start = wr && (addr == `TMAB_A_START);
wire sw_trig = wr && (addr == `TMAB_A_TRIG) && wdata[0];
wire [1:0] ta_mode = ta_mode_reg[1:0];
wire ta_go = start_reg[0];
wire ta_up = ta_mode_reg[`TMAB_TA_UP];
wire ta_free = ta_mode_reg[`TMAB_TA_FREE];
wire new_start = wr_start ? wdata[0] : ta_go;

// Timer A datapath
reg [15:0] ta_cnt_reg;
reg [15:0] ta_rld_reg;
reg [2:0] os_state_reg;
reg os_pend_reg;
reg os_rl_reg;
reg [15:0] pwm_ph_reg;
wire ta_basic = (ta_mode == `TMAB_TA_TIMER) || (ta_mode == `TMAB_TA_EVENT);
wire ta_step = ta_go && ((ta_mode == `TMAB_TA_TIMER) ? tick_reg :
	(ta_mode == `TMAB_TA_EVENT) ? ta_rise : 1'b0);
wire ta_unf = ta_step && !(ta_mode == `TMAB_TA_EVENT && ta_up) &&
	(ta_cnt_reg == `TMAB_ZERO);
wire ta_ovf = ta_step && (ta_mode == `TMAB_TA_EVENT) && ta_up &&
	(ta_cnt_reg == `TMAB_ALL1);
wire ta_trig = sw_trig || (ta_mode_reg[`TMAB_TA_EXT] && ta_rise);
wire os_mode = (ta_mode == `TMAB_TA_ONESHOT);
wire pwm_mode = (ta_mode == `TMAB_TA_PWM);
wire os_stop = os_mode && ta_go && !new_start && (os_state_reg != ST_IDLE);
wire os_end = os_mode && ta_go && tick_reg && (os_state_reg == ST_RUN) &&
	(ta_cnt_reg == `TMAB_ZERO);
wire pwm_stop = pwm_mode && ta_go && !new_start;
wire pwm_high = ta_go && (pwm_ph_reg < ta_rld_reg);
wire pwm_rise = pwm_mode && ta_go && tick_reg && (pwm_ph_reg == `TMAB_ALL1);
wire mode_enter = wr_ta_mode && ta_basic && wdata[1]; // R9 R13
wire ta_req = ta_unf || ta_ovf || os_end || pwm_rise || os_stop ||
	(pwm_stop && timer_a_output_pin) || mode_enter;

always @(posedge clk)
begin
	if (!resetn)
	begin
		ta_cnt_reg <= `TMAB_ZERO;
		ta_rld_reg <= `TMAB_ZERO;
		os_state_reg <= ST_IDLE;
		os_pend_reg <= 1'b0;
		pwm_ph_reg <= `TMAB_ZERO;
	end
	else
	begin
		if (wr_ta_cnt)
			ta_rld_reg <= wdata;
		if (wr_ta_cnt && (!ta_go || ta_free))
			ta_cnt_reg <= wdata; // R2
		else if (ta_unf && !(ta_free && ta_mode == `TMAB_TA_EVENT))
			ta_cnt_reg <= ta_rld_reg;
		else if (ta_ovf && !ta_free)
			ta_cnt_reg <= ta_rld_reg;
		else if (ta_step)
			ta_cnt_reg <= ta_up && ta_mode == `TMAB_TA_EVENT ?
				ta_cnt_reg + 16'h0001 : ta_cnt_reg - 16'h0001;
		else if (os_stop || os_end)
			ta_cnt_reg <= ta_rld_reg; // R7
		else if (os_rl_reg && os_mode && ta_go)
			ta_cnt_reg <= ta_rld_reg; // R10
		else if (os_mode && ta_go && tick_reg)
		begin
			case (os_state_reg)
				ST_RUN:
					ta_cnt_reg <= ta_cnt_reg - 16'h0001;
				ST_RETRIG:
					ta_cnt_reg <= ta_cnt_reg - 16'h0001; // R10
				default:
					ta_cnt_reg <= ta_cnt_reg;
			endcase
		end
		// Trigger waits for the count source so the output is tick aligned
		if (!ta_go || !os_mode)
			os_pend_reg <= 1'b0;
		else if (ta_trig && os_state_reg == ST_IDLE)
			os_pend_reg <= 1'b1; // R8
		else if (tick_reg)
			os_pend_reg <= 1'b0;
		if (os_stop || os_end || !os_mode)
			os_state_reg <= ST_IDLE;
		else
		begin
			case (os_state_reg)
				ST_IDLE:
					if (os_pend_reg && tick_reg)
						os_state_reg <= ST_RUN; // R8
				ST_RUN:
					if (ta_trig)
						os_state_reg <= ST_RETRIG; // R10
				ST_RETRIG:
					if (tick_reg)
						os_state_reg <= ST_RUN;
				default:
					os_state_reg <= ST_IDLE;
			endcase
		end
		if (!pwm_mode || !ta_go)
			pwm_ph_reg <= `TMAB_ALL1;
		else if (tick_reg)
			pwm_ph_reg <= pwm_ph_reg + 16'h0001;
	end
end

// One-shot reload after the extra down count of a retrigger
always @(posedge clk)
begin
	if (!resetn)
		os_rl_reg <= 1'b0;
	else
		os_rl_reg <= os_state_reg == ST_RETRIG && tick_reg && ta_go && os_mode;
end

// Output pin
always @(posedge clk)
begin
	if (!resetn)
		timer_a_output_pin <= 1'b0;
	else if (os_stop || pwm_stop)
		timer_a_output_pin <= 1'b0; // R14
	else if (os_mode)
		timer_a_output_pin <= (os_state_reg != ST_IDLE) && !os_end;
	else if (pwm_mode)
		timer_a_output_pin <= pwm_high;
	else
		timer_a_output_pin <= 1'b0;
end

// Timer B channels
wire [15:0] tb_val [0:NB-1];
wire [NB-1:0] tb_req;
wire [NB-1:0] tb_ovf;
genvar g;
generate
	for (g = 0; g < NB; g = g + 1)
	begin : gen_tb
		wire sel = (addr[2:0] == g);
		reg [2:0] mode_reg;
		always @(posedge clk)
		begin
			if (!resetn)
				mode_reg <= 3'h0;
			else if (wr && is_tb(addr, `TMAB_A_TB_MODE) && sel)
				mode_reg <= wdata[2:0];
		end
		assign tb_mode[g] = mode_reg;
		tmab_timer_b u_tb (
			.clk(clk),
			.resetn(resetn),
			.tick(tick_reg),
			.pin_lvl(tb_s2_reg[g]),
			.start(start_reg[g+1]),
			.mode(mode_reg[1:0]),
			.msel(mode_reg[`TMAB_TB_MSEL]),
			.wr_cnt(wr && is_tb(addr, `TMAB_A_TB_CNT) && sel),
			.wr_mode(wr && is_tb(addr, `TMAB_A_TB_MODE) && sel),
			.wdata(wdata),
			.rd_val(tb_val[g]),
			.req(tb_req[g]),
			.ovf(tb_ovf[g])
		);
	end
endgenerate

// Control, status and mask
wire [NI-1:0] ev = {tb_req, ta_req};
wire wr_stat = wr && (addr == `TMAB_A_IRQ_STAT);
always @(posedge clk)
begin
	if (!resetn)
	begin
		ta_mode_reg <= 5'h00;
		start_reg <= {NI{1'b0}};
		stat_reg <= {NI{1'b0}};
		mask_reg <= {NI{1'b0}};
		irq <= 1'b0;
	end
	else
	begin
		if (wr_ta_mode)
			ta_mode_reg <= wdata[4:0]; // R9 R13
		if (wr_start)
			start_reg <= wdata[NI-1:0];
		if (wr && addr == `TMAB_A_IRQ_MASK)
			mask_reg <= wdata[NI-1:0];
		// New events win over a write-one clear in the same cycle
		stat_reg <= (stat_reg & ~(wr_stat ? wdata[NI-1:0] : {NI{1'b0}})) | ev; // R7
		irq <= |(((stat_reg & ~(wr_stat ? wdata[NI-1:0] : {NI{1'b0}})) | ev) & mask_reg);
	end
end

// Read port
reg [15:0] rd_mux;
always @*
begin
	rd_mux = `TMAB_ZERO;
	if (addr == `TMAB_A_TA_CNT)
		rd_mux = ta_unf ? `TMAB_ALL1 : ta_ovf ? `TMAB_ZERO : ta_cnt_reg; // R1
	else if (addr == `TMAB_A_TA_MODE)
		rd_mux = {11'h000, ta_mode_reg};
	else if (addr == `TMAB_A_START)
		rd_mux = {{(16-NI){1'b0}}, start_reg};
	else if (addr == `TMAB_A_IRQ_STAT)
		rd_mux = {{(16-NI){1'b0}}, stat_reg};
	else if (addr == `TMAB_A_IRQ_MASK)
		rd_mux = {{(16-NI){1'b0}}, mask_reg};
	else if (is_tb(addr, `TMAB_A_TB_CNT))
		rd_mux = tb_val[addr[2:0]]; // R15
	else if (is_tb(addr, `TMAB_A_TB_MODE))
		rd_mux = {12'h000, tb_ovf[addr[2:0]], tb_mode[addr[2:0]]};
end
always @(posedge clk)
begin
	if (!resetn)
		rdata <= `TMAB_ZERO;
	else if (rd)
		rdata <= rd_mux;
	else
		rdata <= `TMAB_ZERO;
end
endmodule // tmab_top
`default_nettype wire

// ===== tb/tmab_monitor.sv
`default_nettype none
module tmab_monitor #(
	parameter DIV = 4,
	parameter NB = 6
) (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [15:0] rdata,
	// Pins and interrupt
	input wire logic timer_a_trigger_input,
	input wire logic [NB-1:0] timer_b_input,
	input wire logic timer_a_output_pin,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ns;
	// Shadows of software writes, since inner state is hidden
	logic [6:0] run_reg;
	logic [6:0] mask_reg;
	logic [4:0] ta_mode_reg;
	logic [2:0] tb_mode_reg;
	logic [15:0] ta_val_reg;
	logic [15:0] tb_val_reg;
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			run_reg <= 7'h00;
			mask_reg <= 7'h00;
			ta_mode_reg <= 5'h00;
			tb_mode_reg <= 3'h0;
			ta_val_reg <= 16'h0000;
			tb_val_reg <= 16'h0000;
		end
		else if (wr)
		begin
			case (addr)
				8'h00: ta_val_reg <= wdata;
				8'h01: ta_mode_reg <= wdata[4:0];
				8'h02: run_reg <= wdata[6:0];
				8'h05: mask_reg <= wdata[6:0];
				8'h08: tb_val_reg <= wdata;
				8'h10: tb_mode_reg <= wdata[2:0];
				default: ;
			endcase
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	chk_ta_readback: assert property (wr && addr == 8'h00 && !run_reg[0]
		##1 !wr ##1 rd && addr == 8'h00 |=> rdata == ta_val_reg)
		else $error("timer A readback wrong");
	chk_tb_readback: assert property (wr && addr == 8'h08 && !run_reg[1]
		##1 !wr ##1 rd && addr == 8'h08 |=> rdata == tb_val_reg)
		else $error("timer B readback wrong");
	chk_oneshot_entry: assert property (wr && addr == 8'h01 && wdata[1:0] == 2'h2
		&& !ta_mode_reg[1] && mask_reg[0] |-> ##[1:3] irq)
		else $error("no request entering one-shot");
	chk_pwm_entry: assert property (wr && addr == 8'h01 && wdata[1:0] == 2'h3
		&& !ta_mode_reg[1] && mask_reg[0] |-> ##3 irq)
		else $error("no request entering pwm");
	chk_oneshot_stop: assert property (wr && addr == 8'h02 && !wdata[0]
		&& run_reg[0] && ta_mode_reg[1:0] == 2'h2 |-> ##2 !timer_a_output_pin [*4])
		else $error("one-shot stop left output high");
	chk_pwm_stop: assert property (wr && addr == 8'h02 && !wdata[0] && run_reg[0]
		&& ta_mode_reg[1:0] == 2'h3 && timer_a_output_pin && mask_reg[0]
		|-> ##3 (irq && !timer_a_output_pin))
		else $error("pwm stop from high wrong");
	chk_trig_delay: assert property ($rose(timer_a_trigger_input) && run_reg[0]
		&& ta_mode_reg[1:0] == 2'h2 && ta_mode_reg[4] |-> ##[4:7] timer_a_output_pin)
		else $error("one-shot output late after trigger");
	chk_msel_change: assert property (wr && addr == 8'h10 && wdata[1:0] == 2'h2
		&& tb_mode_reg[1:0] == 2'h2 && wdata[2] != tb_mode_reg[2] && run_reg[1]
		&& mask_reg[1] |-> ##[1:3] irq)
		else $error("no request on select change");
endmodule // tmab_monitor
bind tmab_top tmab_monitor #(.DIV(DIV), .NB(NB)) u_monitor (
	.clk(clk),
	.resetn(resetn),
	.addr(addr),
	.wdata(wdata),
	.wr(wr),
	.rd(rd),
	.rdata(rdata),
	.timer_a_trigger_input(timer_a_trigger_input),
	.timer_b_input(timer_b_input),
	.timer_a_output_pin(timer_a_output_pin),
	.irq(irq)
);
`default_nettype wire

// ===== tb/tb_top.sv
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk;
	logic resetn;
	logic [7:0] addr;
	logic [15:0] wdata;
	logic wr;
	logic rd;
	logic trig;
	logic [5:0] tb_in;
	logic [15:0] rdata;
	logic pin;
	logic irq;
	logic [15:0] v;
	logic [15:0] v2;
	int miscompares = 0;
	int num_checks = 0;
	int cycles = 0;

	// Small divider keeps every count short
	tmab_top #(.DIV(2), .NB(6)) dut (
		.clk(clk),
		.resetn(resetn),
		.addr(addr),
		.wdata(wdata),
		.wr(wr),
		.rd(rd),
		.rdata(rdata),
		.timer_a_trigger_input(trig),
		.timer_b_input(tb_in),
		.timer_a_output_pin(pin),
		.irq(irq)
	);

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic end_of_test();
		if (miscompares == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cycles = cycles + 1;
		if (cycles == 5000)
		begin
			miscompares = miscompares + 1;
			end_of_test();
		end
	end

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		num_checks = num_checks + 1;
		if (got !== exp)
		begin
			miscompares = miscompares + 1;
			$display("mismatch at %0t: value %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		num_checks = num_checks + 1;
		if (got !== exp)
		begin
			miscompares = miscompares + 1;
			$display("mismatch at %0t: flag %b, expected %b", $time, got, exp);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// Read data stand for one cycle only, so sample mid-cycle
	task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic t_readback();
		rd_reg(8'h0E, v);
		chk16(v, 16'h0000);
		chk1(irq, 1'b0);
		wr_reg(8'h00, 16'h1234);
		rd_reg(8'h00, v);
		chk16(v, 16'h1234);
		for (int i = 0; i < 6; i++)
		begin
			wr_reg(8'h08 + 8'(i), 16'hA5A0 + 16'(i));
			rd_reg(8'h08 + 8'(i), v);
			chk16(v, 16'hA5A0 + 16'(i));
		end
	endtask

	task automatic t_live();
		wr_reg(8'h00, 16'h0100);
		wr_reg(8'h08, 16'h0100);
		wr_reg(8'h02, 16'h0003);
		rd_reg(8'h00, v);
		idle(6);
		rd_reg(8'h00, v2);
		// Eight clocks between the two samples hold four count-source ticks
		chk16(v2, v - 16'h0004);
		rd_reg(8'h08, v);
		idle(6);
		rd_reg(8'h08, v2);
		chk16(v2, v - 16'h0004);
		wr_reg(8'h02, 16'h0000);
	endtask

	task automatic t_oneshot();
		wr_reg(8'h05, 16'h0001);
		wr_reg(8'h01, 16'h0002);
		idle(3);
		chk1(irq, 1'b1);
		wr_reg(8'h05, 16'h0000);
		idle(2);
		chk1(irq, 1'b0);
		wr_reg(8'h05, 16'h0001);
		wr_reg(8'h04, 16'h0001);
		idle(2);
		chk1(irq, 1'b0);
		wr_reg(8'h00, 16'h0008);
		wr_reg(8'h02, 16'h0001);
		wr_reg(8'h03, 16'h0001);
		idle(6);
		wr_reg(8'h03, 16'h0001);
		// Without the retrigger the pulse would already be over here
		idle(12);
		chk1(pin, 1'b1);
		wr_reg(8'h02, 16'h0000);
		idle(3);
		chk1(pin, 1'b0);
		chk1(irq, 1'b1);
		rd_reg(8'h00, v);
		chk16(v, 16'h0008);
		wr_reg(8'h04, 16'h0001);
		wr_reg(8'h01, 16'h0012);
		wr_reg(8'h02, 16'h0001);
		trig <= 1'b1;
		idle(8);
		chk1(pin, 1'b1);
		@(posedge clk);
		trig <= 1'b0;
		idle(20);
		wr_reg(8'h02, 16'h0000);
	endtask

	task automatic t_pwm();
		wr_reg(8'h01, 16'h0000);
		wr_reg(8'h04, 16'h0001);
		wr_reg(8'h01, 16'h0003);
		idle(3);
		chk1(irq, 1'b1);
		wr_reg(8'h00, 16'h8000);
		wr_reg(8'h02, 16'h0001);
		idle(6);
		chk1(pin, 1'b1);
		wr_reg(8'h04, 16'h0001);
		wr_reg(8'h02, 16'h0000);
		idle(3);
		chk1(pin, 1'b0);
		chk1(irq, 1'b1);
		wr_reg(8'h00, 16'h0000);
		wr_reg(8'h02, 16'h0001);
		idle(4);
		wr_reg(8'h04, 16'h0001);
		wr_reg(8'h02, 16'h0000);
		idle(3);
		chk1(irq, 1'b0);
	endtask

	task automatic t_meas();
		wr_reg(8'h05, 16'h0002);
		wr_reg(8'h10, 16'h0002);
		wr_reg(8'h02, 16'h0002);
		wr_reg(8'h04, 16'h007F);
		tb_in <= 6'h01;
		idle(8);
		chk1(irq, 1'b0);
		wr_reg(8'h10, 16'h0006);
		idle(3);
		chk1(irq, 1'b1);
		wr_reg(8'h02, 16'h0000);
	endtask

	// Channel 1 starts near the top so the overflow comes before any edge
	task automatic t_ovf();
		wr_reg(8'h11, 16'h0002);
		wr_reg(8'h09, 16'hFFF0);
		wr_reg(8'h04, 16'h007F);
		wr_reg(8'h02, 16'h0004);
		idle(40);
		rd_reg(8'h11, v);
		chk16(v, 16'h000A);
		rd_reg(8'h04, v);
		chk16(v, 16'h0004);
		wr_reg(8'h11, 16'h0002);
		rd_reg(8'h11, v);
		chk16(v, 16'h0002);
		wr_reg(8'h02, 16'h0000);
	endtask

	task automatic trig_pulse();
		@(posedge clk);
		trig <= 1'b1;
		repeat (3) @(posedge clk);
		trig <= 1'b0;
		repeat (3) @(posedge clk);
	endtask

	task automatic t_event();
		wr_reg(8'h01, 16'h0005);
		wr_reg(8'h00, 16'h0010);
		wr_reg(8'h02, 16'h0001);
		wr_reg(8'h00, 16'h0000);
		trig_pulse();
		wr_reg(8'h01, 16'h000D);
		trig_pulse();
		rd_reg(8'h00, v);
		chk16(v, 16'h0012);
		wr_reg(8'h02, 16'h0000);
		wr_reg(8'h00, 16'h0020);
		rd_reg(8'h00, v);
		chk16(v, 16'h0020);
	endtask

	initial
	begin
		resetn = 1'b0;
		addr = 8'h00;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
		trig = 1'b0;
		tb_in = 6'h00;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		t_readback();
		t_live();
		t_oneshot();
		t_pwm();
		t_meas();
		t_ovf();
		t_event();
		end_of_test();
	end
endmodule // tb_top
`default_nettype wire
